// File: inc/fdd_pkg.sv
// Shared constants for the diskette drive end and the host controller end
package fdd_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned STEP_LOW_US    = 1;
  localparam int unsigned DIR_SETUP_US   = 1;
  localparam int unsigned SIDE_SETTLE_US = 100;
  localparam int unsigned HEAD_LOAD_MS   = 35;
  localparam int unsigned STEP_SETTLE_MS = 15;
  localparam int unsigned STEP_RATE_MS   = 3;
  localparam int unsigned POWER_ON_S     = 2;
  localparam int unsigned RD_PULSE_NS    = 200;
  localparam int unsigned STEP_LOW_CYC   = STEP_LOW_US * CLK_MHZ;
  localparam int unsigned DIR_SETUP_CYC  = DIR_SETUP_US * CLK_MHZ;
  localparam int unsigned SIDE_CYC       = SIDE_SETTLE_US * CLK_MHZ;
  localparam int unsigned HEAD_LOAD_CYC  = HEAD_LOAD_MS * CLK_MHZ * 1000;
  localparam int unsigned SETTLE_CYC     = STEP_SETTLE_MS * CLK_MHZ * 1000;
  localparam int unsigned STEP_RATE_CYC  = STEP_RATE_MS * CLK_MHZ * 1000;
  localparam int unsigned POWER_ON_CYC   = POWER_ON_S * CLK_MHZ * 1000000;
  localparam int unsigned RD_PULSE_CYC   = RD_PULSE_NS * CLK_MHZ / 1000;
  localparam int unsigned WRITE_TRIES    = 4;
  localparam int unsigned READ_TRIES     = 10;
  localparam int unsigned TRACK_MAX      = 76;
  localparam int unsigned RECAL_LIMIT    = 255;
  // Host register map (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CMD    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // CTRL fields
  localparam int CTRL_DRV     = 0;
  localparam int CTRL_SIDE    = 2;
  localparam int CTRL_INDEP   = 3;
  localparam int CTRL_HOLD    = 4;
  // CMD fields
  localparam int CMD_OP       = 0;
  localparam int CMD_TRK      = 8;
  // STATUS fields
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_ERR       = 2;
  localparam int ST_TRK0      = 3;
  localparam int ST_WPROT     = 4;
  localparam int ST_PWR       = 5;
  localparam int ST_TRACK     = 8;
  localparam int ST_TRIES     = 16;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  typedef enum logic [2:0] {OP_NONE, OP_SEEK, OP_RECAL, OP_READ, OP_WRITE} op_t;
endpackage

// File: inc/fdd_if.sv
// Cable between host controller and diskette drive
`timescale 1ns/1ps
`default_nettype none
interface fdd_if;
  logic [3:0] sel_n;
  logic       dir_n;
  logic       step_n;
  logic       wgate_n;
  logic       side_n;
  logic       wdata_n;
  logic       trk0_oe_n;
  logic       wprot_oe_n;
  logic       rd_oe_n;
  logic       sdata_oe_n;
  logic       sclk_oe_n;
  logic       trk0_n;
  logic       wprot_n;
  logic       rd_n;
  logic       sdata_n;
  logic       sclk_n;
  // Open collector outputs with pull-up: line is low only while enabled
  assign trk0_n  = trk0_oe_n;
  assign wprot_n = wprot_oe_n;
  assign rd_n    = rd_oe_n;
  assign sdata_n = sdata_oe_n;
  assign sclk_n  = sclk_oe_n;
  modport drive (input sel_n, dir_n, step_n, wgate_n, side_n, wdata_n,
                 output trk0_oe_n, wprot_oe_n, rd_oe_n, sdata_oe_n, sclk_oe_n);
  modport host (output sel_n, dir_n, step_n, wgate_n, side_n, wdata_n,
                input trk0_n, wprot_n, rd_n, sdata_n, sclk_n);
endinterface
`default_nettype wire

// File: rtl/fdd_drive.sv
// Diskette drive end: select, stepping, side, gating and read pulses
`timescale 1ns/1ps
`default_nettype none
module fdd_drive #(
  parameter logic [1:0] DRIVE_NUM     = 2'h0,
  parameter bit         TWO_SIDED     = 1'b1,
  parameter bit         HAS_PROTECT   = 1'b1,
  parameter bit         HAS_SEPARATOR = 1'b1,
  parameter int         MAX_TRACK     = fdd_pkg::TRACK_MAX
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  fdd_if.drive      cab,
  input  wire logic flux_i,
  input  wire logic sep_data_i,
  input  wire logic sep_clk_i,
  input  wire logic notch_open_i,
  output logic      head_load_o,
  output logic      stepper_on_o,
  output logic      busy_led_o,
  output logic      door_lock_o,
  output logic      write_en_o,
  output logic      write_bit_o,
  output logic      surface_o,
  output logic [6:0] track_o
);
  import fdd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs: three stages, change accepted when stages two and three agree
  logic [8:0] pin_raw;
  logic [8:0] s1_r;
  logic [8:0] s2_r;
  logic [8:0] s3_r;
  logic [8:0] filt_r;
  assign pin_raw = {cab.sel_n, cab.dir_n, cab.step_n, cab.wgate_n, cab.side_n, cab.wdata_n};

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      s1_r   <= 9'h1FF;
      s2_r   <= 9'h1FF;
      s3_r   <= 9'h1FF;
      filt_r <= 9'h1FF;
    end
    else
    begin
      s1_r   <= pin_raw;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & filt_r);
    end

  logic sel;
  logic dir_n;
  logic step_n;
  logic wgate_n;
  logic side_n;
  assign sel     = ~filt_r[5 + DRIVE_NUM];
  assign dir_n   = filt_r[4] | ~sel;
  assign step_n  = filt_r[3] | ~sel;
  assign wgate_n = filt_r[2] | ~sel;
  assign side_n  = filt_r[1] | ~sel;

  ////////////////////////////////////////////////////////////////////////////
  // Head position; inputs are ignored while not selected
  logic [6:0] track_r;
  logic       step_q_r;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      track_r  <= 7'h00;
      step_q_r <= 1'b1;
    end
    else
    begin
      step_q_r <= step_n;
      // Move on the trailing edge, one track per pulse, stop at the stops
      if (step_n && !step_q_r)
      begin
        if (!dir_n && track_r < 7'(MAX_TRACK))
          track_r <= track_r + 7'h01;
        else if (dir_n && track_r != 7'h00)
          track_r <= track_r - 7'h01;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // Read pulses: composite, then separated data and clock
  logic [2:0] trig;
  logic [7:0] pulse_r [3];
  assign trig = {flux_i, sep_data_i & HAS_SEPARATOR, sep_clk_i & HAS_SEPARATOR};

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      for (int k = 0; k < 3; k++)
        pulse_r[k] <= 8'h00;
    end
    else
    begin
      for (int k = 0; k < 3; k++)
        if (trig[2 - k])
          pulse_r[k] <= 8'(RD_PULSE_CYC);
        else if (pulse_r[k] != 8'h00)
          pulse_r[k] <= pulse_r[k] - 8'h01;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: pins float while deselected
  logic protect;
  assign protect = HAS_PROTECT & notch_open_i;

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      head_load_o    <= 1'b0;
      stepper_on_o   <= 1'b0;
      busy_led_o     <= 1'b0;
      door_lock_o    <= 1'b0;
      write_en_o     <= 1'b0;
      write_bit_o    <= 1'b0;
      surface_o      <= 1'b0;
      cab.trk0_oe_n  <= 1'b1;
      cab.wprot_oe_n <= 1'b1;
      cab.rd_oe_n    <= 1'b1;
      cab.sdata_oe_n <= 1'b1;
      cab.sclk_oe_n  <= 1'b1;
    end
    else
    begin
      head_load_o    <= sel;
      stepper_on_o   <= sel;
      busy_led_o     <= sel;
      door_lock_o    <= sel;
      write_en_o     <= sel & ~wgate_n & ~protect;
      write_bit_o    <= sel & ~wgate_n & ~protect & ~filt_r[0];
      surface_o      <= TWO_SIDED & ~side_n;
      // Track zero is signalled only while selected and with the head at track zero
      cab.trk0_oe_n  <= ~(sel && track_r == 7'h00);
      cab.wprot_oe_n <= ~(sel & protect);
      cab.rd_oe_n    <= ~(sel && pulse_r[0] != 8'h00);
      cab.sdata_oe_n <= ~(sel && pulse_r[1] != 8'h00);
      cab.sclk_oe_n  <= ~(sel && pulse_r[2] != 8'h00);
    end

  assign track_o = track_r;
endmodule
`default_nettype wire

// File: rtl/fdd_host.sv
// Host diskette controller: AHB-Lite registers and drive sequencing
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fdd_host #(
  parameter int unsigned T_POWER = fdd_pkg::POWER_ON_CYC,
  parameter int unsigned T_HEAD  = fdd_pkg::HEAD_LOAD_CYC,
  parameter int unsigned T_SETTL = fdd_pkg::SETTLE_CYC,
  parameter int unsigned T_RATE  = fdd_pkg::STEP_RATE_CYC,
  parameter int unsigned T_SIDE  = fdd_pkg::SIDE_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic [31:0]      hrdata_o,
  output logic             hresp_o,
  fdd_if.host              cab,
  input  wire logic        wr_bit_i,
  input  wire logic        wr_done_i,
  input  wire logic        rd_ok_i,
  input  wire logic        rd_bad_i,
  output logic             wr_window_o,
  output logic             rd_window_o,
  output logic             rd_flux_o,
  output logic             rd_sdata_o,
  output logic             rd_sclk_o
);
  import fdd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Drive outputs: three stages, change accepted when stages two and three agree
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] in_r;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      s1_r <= 5'h1F;
      s2_r <= 5'h1F;
      s3_r <= 5'h1F;
      in_r <= 5'h1F;
    end
    else
    begin
      s1_r <= {cab.trk0_n, cab.wprot_n, cab.rd_n, cab.sdata_n, cab.sclk_n};
      s2_r <= s1_r;
      s3_r <= s2_r;
      in_r <= (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & in_r);
    end
  logic at_trk0;
  logic wprot;
  assign at_trk0 = ~in_r[4];
  assign wprot   = ~in_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  typedef enum {S_PWR, S_IDLE, S_SEL, S_DIR, S_STEP, S_GAP, S_SETTLE,
                S_SIDE, S_WRITE, S_VERIFY, S_READ} state_t;
  state_t     st_r;
  logic [4:0] ctrl_r;
  logic       wr_ph_r;
  logic [3:0] addr_r;
  logic       cmd_go;
  logic [15:0] cmd_r;
  logic       done_r;
  logic       err_r;
  logic [6:0] track_r;
  logic [3:0] tries_r;
  logic [31:0] status;
  logic       busy;
  assign busy  = st_r != S_IDLE;
  assign cmd_go = wr_ph_r && addr_r == REG_CMD && !busy;
  assign status = {12'h000, tries_r, 1'b0, track_r, 2'h0, st_r != S_PWR,
                   wprot, at_trk0, err_r, done_r, busy};

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      wr_ph_r  <= 1'b0;
      addr_r   <= 4'h0;
      hrdata_o <= 32'h0000_0000;
    end
    else
    begin
      wr_ph_r <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
      if (hsel_i && hready_i && htrans_i[1])
      begin
        addr_r <= haddr_i[3:0];
        unique case (haddr_i[3:0])
          REG_CTRL:   hrdata_o <= {27'h0, ctrl_r};
          REG_CMD:    hrdata_o <= {16'h0, cmd_r};
          REG_STATUS: hrdata_o <= status;
          default:    hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      ctrl_r <= CTRL_RESET;
      cmd_r  <= 16'h0000;
    end
    else
    begin
      if (wr_ph_r && addr_r == REG_CTRL)
        ctrl_r <= hwdata_i[4:0];
      if (cmd_go)
        cmd_r <= hwdata_i[15:0];
    end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  op_t        op_r;
  logic [31:0] tmr_r;
  logic [6:0] tgt_r;
  logic [6:0] home_r;
  logic       out_r;
  logic [1:0] nudge_r;
  logic [7:0] rc_r;
  logic       sel_r;
  logic       step_r;
  logic       wgate_r;

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      st_r <= S_PWR;
      tmr_r <= T_POWER;
      op_r <= OP_NONE;
      tgt_r <= 7'h00;
      home_r <= 7'h00;
      out_r <= 1'b1;
      nudge_r <= 2'h0;
      rc_r <= 8'h00;
      sel_r <= 1'b0;
      step_r <= 1'b0;
      wgate_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      track_r <= 7'h00;
      tries_r <= 4'h0;
    end
    else
    begin
      if (tmr_r != 32'h0)
        tmr_r <= tmr_r - 32'h1;
      unique case (st_r)
        S_PWR:
          if (tmr_r == 32'h0)
            st_r <= S_IDLE;
        S_IDLE:
        begin
          sel_r <= ctrl_r[CTRL_HOLD] & sel_r;
          if (cmd_go && hwdata_i[2:0] != 3'(OP_NONE))
          begin
            op_r <= op_t'(hwdata_i[2:0]);
            tgt_r <= hwdata_i[CMD_TRK +: 7];
            home_r <= hwdata_i[CMD_TRK +: 7];
            done_r <= 1'b0;
            err_r <= 1'b0;
            tries_r <= 4'h0;
            nudge_r <= 2'h0;
            rc_r <= 8'h00;
            sel_r <= 1'b1;
            tmr_r <= T_HEAD;
            st_r <= S_SEL;
          end
        end
        S_SEL:
          if (tmr_r == 32'h0)
          begin
            tmr_r <= DIR_SETUP_CYC;
            st_r <= S_DIR;
          end
        S_DIR:
          // Direction is set on entry, so it stands a full setup before the step rises
          if (op_r == OP_RECAL && at_trk0)
          begin
            track_r <= 7'h00;
            tmr_r <= 32'h0;
            st_r <= S_SETTLE;
          end
          else if (op_r == OP_RECAL && rc_r == 8'(RECAL_LIMIT))
          begin
            err_r <= 1'b1;
            done_r <= 1'b1;
            st_r <= S_IDLE;
          end
          else if (op_r != OP_RECAL && track_r == tgt_r)
          begin
            tmr_r <= ctrl_r[CTRL_INDEP] ? T_SETTL : 32'h0;
            st_r <= S_SETTLE;
          end
          else
          begin
            out_r <= op_r == OP_RECAL || tgt_r < track_r;
            if (tmr_r == 32'h0 && out_r == (op_r == OP_RECAL || tgt_r < track_r))
            begin
              step_r <= 1'b1;
              tmr_r <= STEP_LOW_CYC;
              st_r <= S_STEP;
            end
          end
        S_STEP:
          if (tmr_r == 32'h0)
          begin
            step_r <= 1'b0;
            track_r <= out_r ? track_r - 7'h01 : track_r + 7'h01;
            rc_r <= rc_r + 8'h01;
            tmr_r <= T_RATE;
            st_r <= S_GAP;
          end
        S_GAP:
          if (tmr_r == 32'h0)
          begin
            tmr_r <= DIR_SETUP_CYC;
            st_r <= S_DIR;
          end
        S_SETTLE:
          if (tmr_r == 32'h0)
          begin
            if (nudge_r == 2'h1)
            begin
              nudge_r <= 2'h2;
              tgt_r <= home_r;
              tmr_r <= DIR_SETUP_CYC;
              st_r <= S_DIR;
            end
            else if (op_r == OP_READ || op_r == OP_WRITE)
            begin
              wgate_r <= op_r == OP_WRITE;
              tmr_r <= T_SIDE;
              st_r <= S_SIDE;
            end
            else
            begin
              done_r <= 1'b1;
              st_r <= S_IDLE;
            end
          end
        S_SIDE:
          if (tmr_r == 32'h0)
          begin
            if (op_r == OP_WRITE && wprot)
            begin
              wgate_r <= 1'b0;
              err_r <= 1'b1;
              done_r <= 1'b1;
              st_r <= S_IDLE;
            end
            else
              st_r <= op_r == OP_WRITE ? S_WRITE : S_READ;
          end
        S_WRITE:
          if (wr_done_i)
          begin
            wgate_r <= 1'b0;
            tries_r <= tries_r + 4'h1;
            st_r <= S_VERIFY;
          end
        S_VERIFY:
          if (rd_ok_i)
          begin
            done_r <= 1'b1;
            st_r <= S_IDLE;
          end
          else if (rd_bad_i && tries_r == 4'(WRITE_TRIES))
          begin
            err_r <= 1'b1;
            done_r <= 1'b1;
            st_r <= S_IDLE;
          end
          else if (rd_bad_i)
          begin
            // Gate back on and let it stand a full settle before new data
            wgate_r <= 1'b1;
            tmr_r <= T_SIDE;
            st_r <= S_SIDE;
          end
        S_READ:
          if (rd_ok_i)
          begin
            done_r <= 1'b1;
            st_r <= S_IDLE;
          end
          else if (rd_bad_i)
          begin
            tries_r <= tries_r + 4'h1;
            if (tries_r + 4'h1 < 4'(READ_TRIES))
              st_r <= S_READ;
            else if (nudge_r == 2'h0)
            begin
              // Step one track further the way the head last moved (in to track 1 from track zero), then return
              nudge_r <= 2'h1;
              tries_r <= 4'h0;
              tgt_r <= out_r ? (track_r == 7'h00 ? 7'h01 : track_r - 7'h01) : track_r + 7'h01;
              tmr_r <= DIR_SETUP_CYC;
              st_r <= S_DIR;
            end
            else
            begin
              err_r <= 1'b1;
              done_r <= 1'b1;
              st_r <= S_IDLE;
            end
          end
      endcase
    end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and user side
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      cab.sel_n   <= 4'hF;
      cab.dir_n   <= 1'b1;
      cab.step_n  <= 1'b1;
      cab.wgate_n <= 1'b1;
      cab.side_n  <= 1'b1;
      cab.wdata_n <= 1'b1;
      wr_window_o <= 1'b0;
      rd_window_o <= 1'b0;
      rd_flux_o   <= 1'b0;
      rd_sdata_o  <= 1'b0;
      rd_sclk_o   <= 1'b0;
    end
    else
    begin
      cab.sel_n   <= sel_r ? ~(4'h1 << ctrl_r[CTRL_DRV +: 2]) : 4'hF;
      cab.dir_n   <= out_r;
      cab.step_n  <= ~step_r;
      cab.wgate_n <= ~wgate_r;
      cab.side_n  <= ~ctrl_r[CTRL_SIDE];
      cab.wdata_n <= ~(st_r == S_WRITE && wr_bit_i);
      wr_window_o <= st_r == S_WRITE;
      rd_window_o <= st_r == S_READ || st_r == S_VERIFY;
      rd_flux_o   <= ~in_r[2];
      rd_sdata_o  <= ~in_r[1];
      rd_sclk_o   <= ~in_r[0];
    end
endmodule
`default_nettype wire

// File: bench/fdd_chk.sv
// Cable timing checks between host and drive
`timescale 1ns/1ps
`default_nettype none
module fdd_chk #(
  parameter int unsigned T_HEAD = 40,
  parameter int unsigned T_RATE = 20,
  parameter int unsigned T_SIDE = 20
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic [3:0] sel_n,
  input wire logic       dir_n,
  input wire logic       step_n,
  input wire logic       wgate_n,
  input wire logic       wdata_n,
  input wire logic       trk0_oe_n,
  input wire logic       rd_oe_n
);
  import fdd_pkg::*;
  logic [15:0] low_r, dir_r, gap_r, sel_r, gate_r, rd_r;
  logic [6:0]  trk_r;
  logic        step_d_r;
  logic        dir_d_r;
  // Saturate so long idle spans never wrap under a limit
  function automatic logic [15:0] up(input logic [15:0] v);
    return v + {15'h0, v != 16'hFFFF};
  endfunction
  ////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {low_r, sel_r, gate_r, rd_r} <= 64'h0;
      {dir_r, gap_r} <= 32'hFFFFFFFF;
      trk_r <= 7'h0;
      step_d_r <= 1'b1;
      dir_d_r <= 1'b1;
    end
    else
    begin
      step_d_r <= step_n;
      dir_d_r <= dir_n;
      low_r <= step_n ? 16'h0 : up(low_r);
      dir_r <= (dir_n != dir_d_r) ? 16'h0 : up(dir_r);
      gap_r <= (step_n && !step_d_r) ? 16'h0 : up(gap_r);
      sel_r <= &sel_n ? 16'h0 : up(sel_r);
      gate_r <= wgate_n ? 16'h0 : up(gate_r);
      rd_r <= rd_oe_n ? 16'h0 : up(rd_r);
      // Own head position, so track zero is judged without the drive's view
      if (step_n && !step_d_r && !sel_n[0])
        trk_r <= dir_n ? trk_r - {6'h0, trk_r != 7'h0} : trk_r + {6'h0, trk_r != 7'h4C};
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  a_step_width: assert property ($rose(step_n) |-> low_r >= STEP_LOW_CYC)
    else $error("step short");
  a_dir_setup: assert property ($rose(step_n) |-> dir_r >= DIR_SETUP_CYC)
    else $error("dir setup");
  a_step_spacing: assert property ($fell(step_n) |-> gap_r >= T_RATE)
    else $error("step rate");
  a_head_settle: assert property ($fell(step_n) || $fell(wgate_n) |-> sel_r >= T_HEAD)
    else $error("head settle");
  a_write_side: assert property ($fell(wdata_n) |-> !wgate_n && gate_r >= T_SIDE)
    else $error("write early");
  a_read_pulse: assert property ($rose(rd_oe_n) |-> rd_r >= RD_PULSE_CYC)
    else $error("read pulse");
  a_track_zero: assert property ((!sel_n[0] && $stable(trk_r))[*6] |-> trk0_oe_n == (trk_r != 7'h0))
    else $error("track zero");
  a_idle_quiet: assert property (sel_n[0][*6] |-> trk0_oe_n && rd_oe_n)
    else $error("idle drive");
  c_step: cover property ($fell(step_n));
  c_wdata: cover property ($fell(wdata_n));
  c_read: cover property ($rose(rd_oe_n));
endmodule
`default_nettype wire

// File: bench/diskette_drive_host_sequencing_tb_top.sv
// Bench: host controller and drive joined by the cable
`timescale 1ns/1ps
`default_nettype none
module diskette_drive_host_sequencing_tb_top;
  import fdd_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, st;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        hsel = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic        flux = 1'b0;
  logic        wbit = 1'b0;
  logic        wdone = 1'b0;
  logic        rok = 1'b0;
  logic        rbad = 1'b0;
  logic        notch = 1'b0;
  logic        side = 1'b0;
  logic        hrdy, hresp, wwin, rwin, rfl, rsd, rsc, hl, son, led, lock, wen, wb, surf;
  logic [6:0]  trk, tgt;
  int          num_errors = 0;
  int          checked = 0;
  int          seed = 15;
  fdd_if cab ();
  fdd_host #(.T_POWER(50), .T_HEAD(40), .T_SETTL(30), .T_RATE(20), .T_SIDE(20)) u_fdd_host (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy), .hrdata_o(hrdata), .hresp_o(hresp),
    .cab(cab.host), .wr_bit_i(wbit), .wr_done_i(wdone), .rd_ok_i(rok), .rd_bad_i(rbad), .wr_window_o(wwin),
    .rd_window_o(rwin), .rd_flux_o(rfl), .rd_sdata_o(rsd), .rd_sclk_o(rsc));
  fdd_drive u_fdd_drive (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cab(cab.drive), .flux_i(flux), .sep_data_i(flux),
    .sep_clk_i(flux), .notch_open_i(notch), .head_load_o(hl), .stepper_on_o(son), .busy_led_o(led),
    .door_lock_o(lock), .write_en_o(wen), .write_bit_o(wb), .surface_o(surf), .track_o(trk));
  fdd_chk u_fdd_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .sel_n(cab.sel_n), .dir_n(cab.dir_n), .step_n(cab.step_n), .wgate_n(cab.wgate_n), .wdata_n(cab.wdata_n),
    .trk0_oe_n(cab.trk0_oe_n), .rd_oe_n(cab.rd_oe_n));
  always #5 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= w;
    do @(posedge sys_clk_i); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_i); while (hrdy !== 1'b1);
    st = hrdata;
  endtask
  task automatic win(input logic w, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((w ? wwin : rwin) !== lvl && n < lim)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n == 20000)
      num_errors++;
  endtask
  // Poll until idle, then compare the status fields we can predict
  task automatic exp_st(input logic [6:0] t, input logic e, input logic p);
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk_i);
    bus(1'b0, REG_STATUS, 32'h0);
    while (st[ST_BUSY] !== 1'b0 && n < 60000)
    begin
      bus(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    chk(st & 32'h7F37, {17'h0, t, 3'h1, p, 1'b0, e, 2'h2});
  endtask
  task automatic ans(input logic bad);
    win(1'b0, 1'b1, 20000);
    rok <= !bad;
    rbad <= bad;
    @(posedge sys_clk_i);
    rok <= 1'b0;
    rbad <= 1'b0;
    win(1'b0, 1'b0, 8);
  endtask
  task automatic wtry(input logic bad);
    win(1'b1, 1'b1, 20000);
    wbit <= 1'($random(seed));
    repeat (8) @(posedge sys_clk_i);
    chk(32'({wen, wb, surf}), {29'h1, wbit, side});
    wdone <= 1'b1;
    @(posedge sys_clk_i);
    wdone <= 1'b0;
    ans(bad);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk(32'({hresp, hrdy, cab.sel_n, cab.step_n, hl, trk}), 32'h3F00);
    bus(1'b1, REG_CMD, 32'h0301);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(32'(st[ST_PWR]), 32'h0);
    repeat (60) @(posedge sys_clk_i);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(st & 32'h7F23, 32'h20);
    for (int i = 0; i < 5; i++)
    begin
      tgt = (i == 0) ? 7'h4C : (i == 4) ? 7'h0 : 7'($unsigned($random(seed)) % 32'h4D);
      bus(1'b1, REG_CTRL, {27'h0, 1'b1, 1'($random(seed)), 3'h0});
      bus(1'b1, REG_CMD, {17'h0, tgt, 8'h1});
      exp_st(tgt, 1'b0, 1'b0);
      chk(32'({hl, son, led, lock, trk}), {21'h0, 4'hF, tgt});
    end
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_CMD, 32'h0201);
    exp_st(7'h2, 1'b0, 1'b0);
    repeat (8) @(posedge sys_clk_i);
    chk(32'(hl), 32'h0);
    bus(1'b1, REG_CTRL, 32'h11);
    bus(1'b1, REG_CMD, 32'h0901);
    exp_st(7'h9, 1'b0, 1'b0);
    chk(32'({hl, trk}), 32'h2);
    bus(1'b1, REG_CTRL, 32'h10);
    bus(1'b1, REG_CMD, 32'h0002);
    exp_st(7'h0, 1'b0, 1'b0);
    chk(32'(trk), 32'h0);
    bus(1'b1, REG_CMD, 32'h0501);
    exp_st(7'h5, 1'b0, 1'b0);
    side = 1'b1;
    bus(1'b1, REG_CTRL, 32'h14);
    bus(1'b1, REG_CMD, 32'h0503);
    win(1'b0, 1'b1, 20000);
    flux <= 1'b1;
    @(posedge sys_clk_i);
    flux <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    chk(32'({rfl, rsd, rsc, surf}), 32'hF);
    ans(1'b1);
    ans(1'b0);
    exp_st(7'h5, 1'b0, 1'b0);
    bus(1'b1, REG_CMD, 32'h0503);
    repeat (20) ans(1'b1);
    exp_st(7'h5, 1'b1, 1'b0);
    chk(32'(trk), 32'h5);
    side = 1'b0;
    bus(1'b1, REG_CTRL, 32'h10);
    bus(1'b1, REG_CMD, 32'h0504);
    repeat (4) wtry(1'b1);
    exp_st(7'h5, 1'b1, 1'b0);
    bus(1'b1, REG_CMD, 32'h0504);
    wtry(1'b1);
    wtry(1'b0);
    exp_st(7'h5, 1'b0, 1'b0);
    notch <= 1'b1;
    bus(1'b1, REG_CMD, 32'h0504);
    exp_st(7'h5, 1'b1, 1'b1);
    chk(32'({wen, cab.wprot_n}), 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk(st, 32'h0);
    results();
  end
  initial
  begin
    #1000000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
